// ===== bdio_pkg.sv
// shared constants for the buffered digital i/o port
package bdio_pkg;

    // port geometry
    localparam int CHANNELS = 12;

    // device code is octal 5X, X from the code-select register
    localparam logic [2:0] DEV_HIGH_DIGIT    = 3'h5;
    localparam logic [2:0] DEV_LOW_DIGIT_RST = 3'h0;

    // operation field values (instruction bits 9..11)
    localparam logic [2:0] OP_IRQ_DISABLE  = 3'h0;
    localparam logic [2:0] OP_IRQ_ENABLE   = 3'h1;
    localparam logic [2:0] OP_SKIP_INPUT   = 3'h2;
    localparam logic [2:0] OP_INPUT_CLEAR  = 3'h3;
    localparam logic [2:0] OP_INPUT_READ   = 3'h4;
    localparam logic [2:0] OP_OUTPUT_CLEAR = 3'h5;
    localparam logic [2:0] OP_OUTPUT_SET   = 3'h6;
    localparam logic [2:0] OP_OUTPUT_READ  = 3'h7;

    // register byte offsets on the configuration bus
    localparam logic [7:0] REG_CODE_SEL  = 8'h00;
    localparam logic [7:0] REG_DIRECT    = 8'h04;
    localparam logic [7:0] REG_FLAG_MASK = 8'h08;
    localparam logic [7:0] REG_STATUS    = 8'h0C;
    localparam logic [7:0] REG_INPUTS    = 8'h10;
    localparam logic [7:0] REG_OUTPUTS   = 8'h14;

    // configuration reset values: latched mode, every bit feeds the flag
    localparam logic [11:0] DIRECT_RST    = 12'h000;
    localparam logic [11:0] FLAG_MASK_RST = 12'hFFF;

    // status word field positions
    localparam int STAT_IRQ_EN_BIT = 0;
    localparam int STAT_FLAG_BIT   = 1;
    localparam int STAT_IRQ_BIT    = 2;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== bdio_cfg_regs.sv
// axi4-lite slave holding the port's configuration and status view
`timescale 1ns/1ps
module bdio_cfg_regs (
    input  wire logic        aclk,          // bus clock
    input  wire logic        aresetn,       // sync reset, low
    input  wire logic        ce,            // clock enable
    input  wire logic [7:0]  s_awaddr,      // write address
    input  wire logic        s_awvalid,     // write address valid
    output logic             s_awready,     // write address ready
    input  wire logic [31:0] s_wdata,       // write data
    input  wire logic [3:0]  s_wstrb,       // byte strobes
    input  wire logic        s_wvalid,      // write data valid
    output logic             s_wready,      // write data ready
    output logic [1:0]       s_bresp,       // write response
    output logic             s_bvalid,      // write response valid
    input  wire logic        s_bready,      // write response ready
    input  wire logic [7:0]  s_araddr,      // read address
    input  wire logic        s_arvalid,     // read address valid
    output logic             s_arready,     // read address ready
    output logic [31:0]      s_rdata,       // read data
    output logic [1:0]       s_rresp,       // read response
    output logic             s_rvalid,      // read data valid
    input  wire logic        s_rready,      // read data ready
    input  wire logic [11:0] in_view,       // input bits as reported
    input  wire logic [11:0] out_view,      // output flip-flops
    input  wire logic [2:0]  stat_view,     // irq enable, flag, irq
    output logic [2:0]       code_digit,    // low octal digit of code
    output logic [11:0]      direct_mask,   // 1 = bit reads line directly
    output logic [11:0]      flag_mask      // 1 = bit feeds pending flag
);
    logic        aw_q, w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [2:0]  code_q;
    logic [11:0] direct_q, flag_q;

    // merge byte lanes of a 12-bit field
    function automatic logic [11:0] lane_merge(input logic [11:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        lane_merge = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // address and data are taken in either order and held until both arrive
    assign s_awready = !aw_q && !s_bvalid;
    assign s_wready  = !w_q && !s_bvalid;
    assign s_arready = !s_rvalid;
    wire   wr_go     = aw_q && w_q && !s_bvalid;
    wire   wr_hit    = awaddr_q == bdio_pkg::REG_CODE_SEL || awaddr_q == bdio_pkg::REG_DIRECT
                    || awaddr_q == bdio_pkg::REG_FLAG_MASK;
    wire   rd_hit    = s_araddr <= bdio_pkg::REG_OUTPUTS && s_araddr[1:0] == 2'h0;

    // read mux, status registers are read-only views of the port
    logic [31:0] rd_word;
    always_comb begin
        case (s_araddr)
            bdio_pkg::REG_CODE_SEL:  rd_word = {29'h0, code_q};
            bdio_pkg::REG_DIRECT:    rd_word = {20'h0, direct_q};
            bdio_pkg::REG_FLAG_MASK: rd_word = {20'h0, flag_q};
            bdio_pkg::REG_STATUS:    rd_word = {29'h0, stat_view};
            bdio_pkg::REG_INPUTS:    rd_word = {20'h0, in_view};
            bdio_pkg::REG_OUTPUTS:   rd_word = {20'h0, out_view};
            default:                 rd_word = 32'h0;
        endcase
    end

    // write channel collection and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp  <= bdio_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (wr_go) begin
                aw_q     <= 1'b0;
                w_q      <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp  <= wr_hit ? bdio_pkg::RESP_OKAY : bdio_pkg::RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers; unmapped writes leave them untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q   <= bdio_pkg::DEV_LOW_DIGIT_RST;
            direct_q <= bdio_pkg::DIRECT_RST;
            flag_q   <= bdio_pkg::FLAG_MASK_RST;
        end else if (ce && wr_go) begin
            if (awaddr_q == bdio_pkg::REG_CODE_SEL && wstrb_q[0])
                code_q <= wdata_q[2:0];
            if (awaddr_q == bdio_pkg::REG_DIRECT)
                direct_q <= lane_merge(direct_q, wdata_q, wstrb_q);
            if (awaddr_q == bdio_pkg::REG_FLAG_MASK)
                flag_q <= lane_merge(flag_q, wdata_q, wstrb_q);
        end
    end

    // read channel: one outstanding read, data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= bdio_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_word;
                s_rresp  <= rd_hit ? bdio_pkg::RESP_OKAY : bdio_pkg::RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    assign code_digit  = code_q;
    assign direct_mask = direct_q;
    assign flag_mask   = flag_q;
endmodule

// ===== bdio_port.sv
// buffered digital i/o port: transfer-instruction decode, input latches, output flip-flops
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bdio_port (
    input  wire logic        aclk,             // system clock, 10 MHz
    input  wire logic        aresetn,          // sync reset, low
    input  wire logic        ce,               // clock enable, freezes state
    input  wire logic        sys_init,         // processor initialize, high
    input  wire logic        io_pause,         // i/o pause level of transfer cycle
    input  wire logic        time_pulse_three, // third time pulse
    input  wire logic [3:11] instr_bits_n,     // instruction bits 3..11, low true
    input  wire logic [0:11] bus_data_in_n,    // accumulator on data bus, low true
    output logic      [0:11] bus_data_out_n,   // read word to data bus, low true
    output logic             bus_data_oe_n,    // low while driving data bus
    output logic             skip_out_n,       // skip line level, low = skip
    output logic             skip_oe_n,        // low while driving skip line
    output logic             io_select,        // port selected
    output logic             internal_io,      // internal i/o indication
    output logic             irq_req,          // program interrupt request
    input  wire logic [11:0] ext_in_n,         // external inputs, low true
    output logic      [11:0] ext_out_n,        // external outputs, low true
    input  wire logic [7:0]  s_awaddr,         // axi write address
    input  wire logic        s_awvalid,        // axi write address valid
    output logic             s_awready,        // axi write address ready
    input  wire logic [31:0] s_wdata,          // axi write data
    input  wire logic [3:0]  s_wstrb,          // axi byte strobes
    input  wire logic        s_wvalid,         // axi write data valid
    output logic             s_wready,         // axi write data ready
    output logic [1:0]       s_bresp,          // axi write response
    output logic             s_bvalid,         // axi write response valid
    input  wire logic        s_bready,         // axi write response ready
    input  wire logic [7:0]  s_araddr,         // axi read address
    input  wire logic        s_arvalid,        // axi read address valid
    output logic             s_arready,        // axi read address ready
    output logic [31:0]      s_rdata,          // axi read data
    output logic [1:0]       s_rresp,          // axi read response
    output logic             s_rvalid,         // axi read data valid
    input  wire logic        s_rready          // axi read data ready
);
    typedef enum logic [3:0] {
        BDIO_OP_NONE,
        BDIO_OP_IRQ_DISABLE,
        BDIO_OP_IRQ_ENABLE,
        BDIO_OP_SKIP,
        BDIO_OP_IN_CLEAR,
        BDIO_OP_IN_READ,
        BDIO_OP_OUT_CLEAR,
        BDIO_OP_OUT_SET,
        BDIO_OP_OUT_READ
    } bdio_op_t;

    logic [11:0] latch_q, latch_d;      // input latches
    logic [11:0] out_q, out_d;          // output flip-flops
    logic [11:0] line_prev_q;           // last sampled line, for edge detect
    logic        irq_en_q, irq_en_d;    // interrupt enable flag
    logic [2:0]  code_digit;
    logic [11:0] direct_mask, flag_mask;
    bdio_op_t    op;

    // select one operation strobe from the three-bit field
    function automatic bdio_op_t op_decode(input logic [2:0] f);
        case (f)
            bdio_pkg::OP_IRQ_DISABLE:  op_decode = BDIO_OP_IRQ_DISABLE;
            bdio_pkg::OP_IRQ_ENABLE:   op_decode = BDIO_OP_IRQ_ENABLE;
            bdio_pkg::OP_SKIP_INPUT:   op_decode = BDIO_OP_SKIP;
            bdio_pkg::OP_INPUT_CLEAR:  op_decode = BDIO_OP_IN_CLEAR;
            bdio_pkg::OP_INPUT_READ:   op_decode = BDIO_OP_IN_READ;
            bdio_pkg::OP_OUTPUT_CLEAR: op_decode = BDIO_OP_OUT_CLEAR;
            bdio_pkg::OP_OUTPUT_SET:   op_decode = BDIO_OP_OUT_SET;
            bdio_pkg::OP_OUTPUT_READ:  op_decode = BDIO_OP_OUT_READ;
            default:                   op_decode = BDIO_OP_NONE;
        endcase
    endfunction

    // bus bits are numbered with bit 0 as the most significant
    function automatic logic [11:0] bus_to_vec(input logic [0:11] b);
        bus_to_vec = b;
    endfunction

    // device select: bits 3..8 are the code, sampled only in the pause
    wire [2:0]  dev_high  = ~instr_bits_n[3:5];
    wire [2:0]  dev_low   = ~instr_bits_n[6:8];
    wire [2:0]  op_field_bits = ~instr_bits_n[9:11];
    wire        code_hit  = dev_high == bdio_pkg::DEV_HIGH_DIGIT && dev_low == code_digit;
    assign io_select   = io_pause && code_hit;
    assign internal_io = io_select;
    assign op = io_select ? op_decode(op_field_bits) : BDIO_OP_NONE;

    // named strobes; the state-changing ones act on the third time pulse
    wire irq_disable_op    = op == BDIO_OP_IRQ_DISABLE;
    wire irq_enable_op     = op == BDIO_OP_IRQ_ENABLE;
    wire skip_on_input_op  = op == BDIO_OP_SKIP;
    wire input_clear_op    = op == BDIO_OP_IN_CLEAR;
    wire input_read_op     = op == BDIO_OP_IN_READ;
    wire output_clear_op   = op == BDIO_OP_OUT_CLEAR;
    wire output_set_op     = op == BDIO_OP_OUT_SET;
    wire output_read_op    = op == BDIO_OP_OUT_READ;
    wire act               = time_pulse_three;
    wire [11:0] accumulator = ~bus_to_vec(bus_data_in_n); // low-true bus to ones

    // external side: low-true lines, falling edge seen against last sample
    wire [11:0] line_now  = ~ext_in_n;
    wire [11:0] fall      = line_now & ~line_prev_q;
    wire [11:0] in_bits   = (direct_mask & line_now) | (~direct_mask & latch_q);
    wire        in_flag   = |(in_bits & flag_mask);
    assign irq_req   = in_flag && irq_en_q;
    assign ext_out_n = ~out_q;

    // latch next value: an edge in the clearing cycle still sets the bit
    genvar gi;
    generate
        for (gi = 0; gi < bdio_pkg::CHANNELS; gi++) begin : g_latch
            wire clr_bit = input_clear_op && act && accumulator[gi];
            assign latch_d[gi] = sys_init ? 1'b0 : (fall[gi] || (latch_q[gi] && !clr_bit));
        end
    endgenerate

    // output next value; set and clear strobes are mutually exclusive by decode
    assign out_d = sys_init ? 12'h000
                 : (output_clear_op && act) ? (out_q & ~accumulator)
                 : (output_set_op && act) ? (out_q | accumulator)
                 : out_q;

    // interrupt enable; initialize is the power-on path and overrides all
    assign irq_en_d = sys_init ? 1'b0
                    : (irq_enable_op && act) ? 1'b1
                    : (irq_disable_op && act) ? 1'b0
                    : irq_en_q;

    // responses drive the bus only during their own strobe, never else
    assign skip_oe_n      = !(skip_on_input_op && in_flag);
    assign skip_out_n     = 1'b0;
    assign bus_data_oe_n  = !(input_read_op || output_read_op);
    assign bus_data_out_n = input_read_op ? ~in_bits : ~out_q;

    // state flip-flops, all frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q     <= 12'h000;
            out_q       <= 12'h000;
            line_prev_q <= 12'h000;
            irq_en_q    <= 1'b0;
        end else if (ce) begin
            latch_q     <= latch_d;
            out_q       <= out_d;
            line_prev_q <= line_now;
            irq_en_q    <= irq_en_d;
        end
    end

    // configuration and status over the register bus
    bdio_cfg_regs u_regs (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ce          (ce),
        .s_awaddr    (s_awaddr),
        .s_awvalid   (s_awvalid),
        .s_awready   (s_awready),
        .s_wdata     (s_wdata),
        .s_wstrb     (s_wstrb),
        .s_wvalid    (s_wvalid),
        .s_wready    (s_wready),
        .s_bresp     (s_bresp),
        .s_bvalid    (s_bvalid),
        .s_bready    (s_bready),
        .s_araddr    (s_araddr),
        .s_arvalid   (s_arvalid),
        .s_arready   (s_arready),
        .s_rdata     (s_rdata),
        .s_rresp     (s_rresp),
        .s_rvalid    (s_rvalid),
        .s_rready    (s_rready),
        .in_view     (in_bits),
        .out_view    (out_q),
        .stat_view   ({irq_req, in_flag, irq_en_q}),
        .code_digit  (code_digit),
        .direct_mask (direct_mask),
        .flag_mask   (flag_mask)
    );

    // checks on the port's own behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sel_pause_a: assert property (
        io_select |-> io_pause && dev_high == bdio_pkg::DEV_HIGH_DIGIT)
        else $error("select without pause or wrong code");

    one_strobe_a: assert property (
        io_select |-> $onehot({irq_disable_op, irq_enable_op, skip_on_input_op, input_clear_op,
                               input_read_op, output_clear_op, output_set_op, output_read_op}))
        else $error("selected cycle did not give exactly one strobe");

    irq_enable_a: assert property (
        ce && !sys_init && irq_enable_op && act |=> irq_en_q ##1 (irq_en_q || !$past(ce) ||
                                                   $past(sys_init) || $past(irq_disable_op)))
        else $error("interrupt enable not set by enable op");

    irq_disable_a: assert property (
        ce && irq_disable_op && act |=> !irq_en_q)
        else $error("interrupt enable not cleared by disable op");

    irq_out_a: assert property (
        irq_req |-> irq_en_q && |(in_bits & flag_mask))
        else $error("interrupt without enable and flag");

    edge_latch_a: assert property (
        ce && !sys_init |=> (latch_q & $past(fall)) == $past(fall))
        else $error("falling input edge not latched");

    in_clear_a: assert property (
        ce && !sys_init && input_clear_op && act
        |=> (latch_q & ~$past(accumulator)) == ($past(latch_q) & ~$past(accumulator))
            && (latch_q & $past(accumulator)) == ($past(fall) & $past(accumulator)))
        else $error("input clear touched wrong bits");

    out_set_a: assert property (
        ce && !sys_init && output_set_op && act |=> out_q == ($past(out_q) | $past(accumulator)))
        else $error("output set wrong");

    out_clear_a: assert property (
        ce && !sys_init && output_clear_op && act |=> out_q == ($past(out_q) & ~$past(accumulator)))
        else $error("output clear wrong");

    init_clear_a: assert property (
        ce && sys_init |=> out_q == 12'h000 && latch_q == 12'h000 && !irq_en_q)
        else $error("initialize did not clear port");

    bus_drive_a: assert property (
        !bus_data_oe_n || !skip_oe_n |-> io_select && io_pause)
        else $error("bus lines driven while not selected");

    read_word_a: assert property (
        output_read_op |-> bus_data_out_n == ~out_q && !bus_data_oe_n)
        else $error("output read word wrong");

    // select, bus release, input path, outputs and interrupt enable
    internal_a: assert property (
        internal_io == io_select)
        else $error("internal i/o wrong");

    sel_code_a: assert property (
        io_pause && code_hit |-> io_select)
        else $error("no select on match");

    pause_gate_a: assert property (
        !io_pause |-> !io_select)
        else $error("select outside pause");

    op_idle_a: assert property (
        !io_select |-> op == BDIO_OP_NONE)
        else $error("strobe while idle");

    skip_on_a: assert property (
        skip_on_input_op && in_flag |-> !skip_oe_n && !skip_out_n)
        else $error("skip missing");

    skip_off_a: assert property (
        skip_on_input_op && !in_flag |-> skip_oe_n)
        else $error("skip without flag");

    skip_quiet_a: assert property (
        !skip_on_input_op |-> skip_oe_n)
        else $error("skip line driven");

    in_read_a: assert property (
        input_read_op |-> bus_to_vec(bus_data_out_n) == ~in_bits && !bus_data_oe_n)
        else $error("input read word wrong");

    data_quiet_a: assert property (
        !input_read_op && !output_read_op |-> bus_data_oe_n)
        else $error("data bus driven");

    out_keep_a: assert property (
        ce && !sys_init && !(act && (output_set_op || output_clear_op))
        |=> out_q == $past(out_q))
        else $error("output changed");

    ext_out_a: assert property (
        ext_out_n == ~out_q)
        else $error("outputs not low true");

    irq_on_a: assert property (
        irq_en_q && |(in_bits & flag_mask) |-> irq_req)
        else $error("interrupt missing");

    en_keep_a: assert property (
        ce && !sys_init && !(act && (irq_enable_op || irq_disable_op))
        |=> irq_en_q == $past(irq_en_q))
        else $error("enable changed");

    latch_rise_a: assert property (
        ce && !sys_init |=> (latch_q & ~$past(latch_q) & ~$past(fall)) == 12'h000)
        else $error("latch set without edge");

    latch_keep_a: assert property (
        ce && !sys_init && !(input_clear_op && act)
        |=> (latch_q & $past(latch_q)) == $past(latch_q))
        else $error("latch dropped");

    direct_bit_a: assert property (
        (in_bits & direct_mask) == (~ext_in_n & direct_mask))
        else $error("direct bit wrong");

    latched_bit_a: assert property (
        (in_bits & ~direct_mask) == (latch_q & ~direct_mask))
        else $error("latched bit wrong");

    code_low_a: assert property (
        io_select |-> dev_low == code_digit)
        else $error("wrong code digit");

    init_out_a: assert property (
        ce && sys_init |=> ext_out_n == 12'hFFF)
        else $error("output left on");

    flag_src_a: assert property (
        in_flag |-> |(latch_q | ~ext_in_n))
        else $error("flag without input");

endmodule

// ===== bdio_cpu_model.sv
// processor model issuing i/o transfer instructions to the port
`timescale 1ns/1ps
module bdio_cpu_model (
    input  wire logic        aclk,             // system clock
    output logic             io_pause,         // i/o pause level
    output logic             time_pulse_three, // third time pulse
    output logic      [3:11] instr_bits_n,     // instruction, low true
    output logic      [0:11] bus_data_in_n,    // accumulator, low true
    input  wire logic [0:11] bus_data_out_n,   // read word, low true
    input  wire logic        bus_data_oe_n,    // port drives data bus
    input  wire logic        skip_oe_n,        // port pulls skip
    input  wire logic        io_select,        // port selected
    input  wire logic        irq_req           // interrupt request
);
    // idle bus: no pause, lines high
    initial begin
        io_pause = 1'b0;
        time_pulse_three = 1'b0;
        instr_bits_n = 9'h1FF;
        bus_data_in_n = 12'hFFF;
    end
    // one cycle: pause opens decode, pulse three acts, answer taken at its end
    task automatic io_transfer_instruction(input logic [2:0] x, input logic [2:0] op,
                       input logic [11:0] acc, output logic [15:0] res);
        @(posedge aclk);
        io_pause <= 1'b1;
        instr_bits_n <= ~{3'h5, x, op};
        bus_data_in_n <= ~acc;
        @(posedge aclk);
        time_pulse_three <= 1'b1;
        @(posedge aclk);
        res = {irq_req, io_select, ~skip_oe_n, ~bus_data_oe_n,
               bus_data_oe_n ? 12'h000 : ~bus_data_out_n};
        io_pause <= 1'b0;
        time_pulse_three <= 1'b0;
        // released lines flip so a stale word never passes for a live one
        instr_bits_n <= ~instr_bits_n;
        bus_data_in_n <= ~bus_data_in_n;
    endtask
endmodule

// ===== tb.sv
// self-checking bench for the buffered digital i/o port
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module tb;
    typedef struct {logic [2:0] x, op; logic [11:0] acc, ext; logic [15:0] exp;} bdio_row_t;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, sys_init = 1'b0;
    logic        io_pause, time_pulse_three, bus_data_oe_n, skip_out_n, skip_oe_n;
    logic        io_select, internal_io, irq_req, s_awready, s_wready, s_bvalid;
    logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0;
    logic        s_arready, s_rvalid, s_rready = 1'b0;
    logic [1:0]  s_bresp, s_rresp;
    logic [3:0]  s_wstrb = 4'hF;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:11] instr_bits_n;
    logic [0:11] bus_data_in_n, bus_data_out_n;
    logic [11:0] ext_in_n = 12'hFFF, ext_out_n;
    logic [15:0] res;
    int          n_errors = 0, checks = 0, cyc = 0;
    // x, op, accumulator, lines low, expected {irq, select, skip, drive, word}
    bdio_row_t rows [15] = '{
        '{3'h0, 3'h7, 12'h000, 12'h000, 16'h5000},
        '{3'h0, 3'h6, 12'hA5C, 12'h000, 16'h4000},
        '{3'h0, 3'h7, 12'h000, 12'h000, 16'h5A5C},
        '{3'h0, 3'h5, 12'h00C, 12'h000, 16'h4000},
        '{3'h0, 3'h7, 12'h000, 12'h000, 16'h5A50},
        '{3'h0, 3'h2, 12'h000, 12'h000, 16'h4000},
        '{3'h0, 3'h4, 12'h000, 12'h801, 16'h5801},
        '{3'h0, 3'h2, 12'h000, 12'h801, 16'h6000},
        '{3'h0, 3'h3, 12'h001, 12'h801, 16'h4000},
        '{3'h0, 3'h4, 12'h000, 12'h801, 16'h5800},
        '{3'h0, 3'h1, 12'h000, 12'h801, 16'h4000},
        '{3'h0, 3'h7, 12'h000, 12'h801, 16'hDA50},
        '{3'h0, 3'h0, 12'h000, 12'h801, 16'hC000},
        '{3'h0, 3'h7, 12'h000, 12'h801, 16'h5A50},
        '{3'h1, 3'h7, 12'h000, 12'h801, 16'h0000}};
    bdio_port uut (.aclk, .aresetn, .ce, .sys_init, .io_pause, .time_pulse_three,
        .instr_bits_n, .bus_data_in_n, .bus_data_out_n, .bus_data_oe_n, .skip_out_n,
        .skip_oe_n, .io_select, .internal_io, .irq_req, .ext_in_n, .ext_out_n,
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
        .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready);
    bdio_cpu_model cpu (.aclk, .io_pause, .time_pulse_three, .instr_bits_n,
        .bus_data_in_n, .bus_data_out_n, .bus_data_oe_n, .skip_oe_n, .io_select, .irq_req);
    always #50 aclk = ~aclk;
    // ceiling far above the under two hundred cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // axi write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw && s_awready === 1'b1) begin
                aw = 1'b0;
                s_awvalid <= 1'b0;
            end
            if (w && s_wready === 1'b1) begin
                w = 1'b0;
                s_wvalid <= 1'b0;
            end
        end while (aw || w);
        s_bready <= 1'b1;
        do @(posedge aclk); while (s_bvalid !== 1'b1);
        s_bready <= 1'b0;
        `CHK("bresp", er, s_bresp)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do @(posedge aclk); while (s_arready !== 1'b1);
        s_arvalid <= 1'b0;
        s_rready <= 1'b1;
        do @(posedge aclk); while (s_rvalid !== 1'b1);
        s_rready <= 1'b0;
        `CHK("rdata", e, s_rdata)
        `CHK("rresp", er, s_rresp)
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK("ext_out", 12'hFFF, ext_out_n)
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h08, 32'hFFF, 2'h0);
        foreach (rows[i]) begin
            ext_in_n <= ~rows[i].ext;
            repeat (2) @(posedge aclk);
            cpu.io_transfer_instruction(rows[i].x, rows[i].op, rows[i].acc, res);
            `CHK("row", rows[i].exp, res)
            `CHK("internal_io", rows[i].exp[14], internal_io)
        end
        `CHK("ext_out", 12'h5AF, ext_out_n)
        `CHK("skip_out", 1'b0, skip_out_n)
        wr(8'h00, 32'h5, 2'h0);
        cpu.io_transfer_instruction(3'h5, 3'h7, 12'h000, res);
        `CHK("code5", 16'h5A50, res)
        wr(8'h0C, 32'h0, 2'h2);
        rd(8'h40, 32'h0, 2'h2);
        // bit 1 read live from its line, the rest still latched
        wr(8'h04, 32'h002, 2'h0);
        ext_in_n <= ~12'h803;
        rd(8'h10, 32'h802, 2'h0);
        rd(8'h0C, 32'h2, 2'h0);
        wr(8'h08, 32'h0, 2'h0);
        rd(8'h0C, 32'h0, 2'h0);
        cpu.io_transfer_instruction(3'h5, 3'h1, 12'h000, res);
        rd(8'h0C, 32'h1, 2'h0);
        sys_init <= 1'b1;
        ext_in_n <= ~12'h801;
        @(posedge aclk);
        sys_init <= 1'b0;
        rd(8'h0C, 32'h0, 2'h0);
        rd(8'h14, 32'h0, 2'h0);
        rd(8'h10, 32'h0, 2'h0);
        `CHK("ext_out", 12'hFFF, ext_out_n)
        // a frozen port decodes but must not act on the set strobe
        ce <= 1'b0;
        cpu.io_transfer_instruction(3'h5, 3'h6, 12'hFFF, res);
        ce <= 1'b1;
        `CHK("ce_sel", 16'h4000, res)
        @(posedge aclk);
        `CHK("ce_hold", 12'hFFF, ext_out_n)
        report_and_stop();
    end
endmodule
